/* File: src/odi_integrator.v */
// The placing of the registers and strobed register access were decided locally.
`include "odi_regs.vh"
`default_nettype none
module odi_integrator #(
  parameter ADC_W = 14,
  parameter ACC_W = 32
) (
  // Clock and reset
  input wire CLK_SYS_IN,
  input wire RST_IN,
  // Register port
  input wire [7:0] REG_ADDR_IN,
  input wire [15:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  output reg [15:0] REG_RDATA_OUT,
  // Timing core
  input wire SLOT_A_START_IN,
  input wire SLOT_B_START_IN,
  // Converter
  input wire [ADC_W-1:0] ADC_CH1_IN,
  input wire [ADC_W-1:0] ADC_CH2_IN,
  input wire [ADC_W-1:0] ADC_CH3_IN,
  input wire [ADC_W-1:0] ADC_CH4_IN,
  input wire ADC_VALID_IN,
  output reg ADC_CONVERT_OUT,
  // Analog control
  output reg BPF_BYPASS_OUT,
  output reg INTEG_BUFFER_OUT,
  output reg SINGLE_CHANNEL_OUT,
  output reg [2:0] CH_POWER_DOWN_OUT,
  output reg [3:0] PD_SELECT_OUT,
  output reg PD_CONNECT_OUT,
  // Decimation and FIFO
  output reg DEC_VALID_OUT,
  output reg DEC_SLOT_OUT,
  output reg [ACC_W-1:0] DEC_DATA_OUT,
  output reg [ACC_W-1:0] DEC_DARK_OUT,
  output reg FIFO_WR_OUT,
  output reg [2:0] FIFO_FMT_OUT,
  output reg BUSY_OUT
);
  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam integer PER_CYC =
    `ODI_CONV_PERIOD_NS / `ODI_CLK_PERIOD_NS;
  localparam [5:0] PER_LAST = PER_CYC[5:0] - 6'h01;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_WAIT = 3'h1;
  localparam [2:0] S_NEG1 = 3'h2;
  localparam [2:0] S_GAP = 3'h3;
  localparam [2:0] S_POS = 3'h4;
  localparam [2:0] S_NEG2 = 3'h5;
  localparam [2:0] S_FIN = 3'h6;
  localparam integer BIAS_I = `ODI_START_BIAS;
  localparam [8:0] BIAS = BIAS_I[8:0];
  localparam [8:0] ONE9 = 9'h001;
  localparam [8:0] TWO9 = 9'h002;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] fifo_cfg_reg;
  reg [15:0] pd_sel_reg;
  reg [15:0] chan_reg;
  reg [15:0] pwr_reg;
  reg [15:0] mode_reg;
  reg [15:0] di_cfg_reg;
  reg [7:0] start_a_reg;
  reg [7:0] width_a_reg;
  reg [7:0] gap_a_reg;
  reg [7:0] start_b_reg;
  reg [7:0] width_b_reg;
  reg [7:0] gap_b_reg;
  reg [ACC_W-1:0] res_a_reg;
  reg [ACC_W-1:0] drk_a_reg;
  reg [ACC_W-1:0] res_b_reg;
  reg [ACC_W-1:0] drk_b_reg;

  // Engine state
  reg [2:0] state_reg;
  reg [5:0] tick_reg;
  reg [8:0] cnt_reg;
  reg slot_reg;
  reg pend_reg;
  reg pend_neg_reg;
  reg [ACC_W-1:0] acc_reg;
  reg [ACC_W-1:0] drk_reg;
  // Sum including a result landing in the final cycle
  reg [ACC_W-1:0] final_sum;
  reg [ACC_W-1:0] final_drk;

  // ----------------------------------------
  // Slot selection
  // ----------------------------------------
  wire di_en_a = mode_reg[`ODI_B_DI_EN_A];
  wire di_en_b = mode_reg[`ODI_B_DI_EN_B];
  wire go_a = SLOT_A_START_IN & di_en_a;
  wire go_b = SLOT_B_START_IN & di_en_b & ~go_a;
  wire go = (state_reg == S_IDLE) & (go_a | go_b);
  // Slot under way, or the one about to start
  wire cur = go ? go_b : slot_reg;
  wire [7:0] w8 = cur ? width_b_reg : width_a_reg;
  wire [8:0] w9 = (w8 == 8'h00) ? ONE9 : {1'b0, w8};
  wire [7:0] st8 = cur ? start_b_reg : start_a_reg;
  wire [7:0] gap8 = cur ? gap_b_reg : gap_a_reg;
  // Config bits; pair1, gapped and fmt are only looked at while a window runs, single and pd8 at all times
  wire pair1 = cur ? di_cfg_reg[`ODI_B_PAIR1_B]
                   : di_cfg_reg[`ODI_B_PAIR1_A];
  wire gapped = di_cfg_reg[`ODI_B_GAPPED];
  wire single = cur ? chan_reg[`ODI_B_SINGLE_B]
                    : chan_reg[`ODI_B_SINGLE_A];
  wire [3:0] pd8 = cur ? pd_sel_reg[`ODI_F_PD_B_HI:`ODI_F_PD_B_LO]
                       : pd_sel_reg[`ODI_F_PD_A_HI:`ODI_F_PD_A_LO];
  wire [2:0] fmt = cur ? fifo_cfg_reg[`ODI_F_FIFO_B_HI:`ODI_F_FIFO_B_LO]
                       : fifo_cfg_reg[`ODI_F_FIFO_A_HI:`ODI_F_FIFO_A_LO];
  wire [8:0] pos_len = pair1 ? w9 : {w9[7:0], 1'b0};

  // ----------------------------------------
  // Sample combining
  // ----------------------------------------
  // Four channels of 14 bits never exceed 16 bits
  wire [15:0] c1 = {{(16-ADC_W){1'b0}}, ADC_CH1_IN};
  wire [15:0] c2 = {{(16-ADC_W){1'b0}}, ADC_CH2_IN};
  wire [15:0] c3 = {{(16-ADC_W){1'b0}}, ADC_CH3_IN};
  wire [15:0] c4 = {{(16-ADC_W){1'b0}}, ADC_CH4_IN};
  wire [15:0] samp = single ? c1 : c1 + c2 + c3 + c4;
  wire [ACC_W-1:0] samp_x = {{(ACC_W-16){1'b0}}, samp};
  wire tick = (tick_reg == PER_LAST);
  wire in_region = (state_reg == S_NEG1) | (state_reg == S_POS) |
                   (state_reg == S_NEG2);

  // ----------------------------------------
  // Integration engine
  // ----------------------------------------
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      state_reg <= S_IDLE;
      tick_reg <= 6'h00;
      cnt_reg <= 9'h000;
      slot_reg <= 1'b0;
      pend_reg <= 1'b0;
      pend_neg_reg <= 1'b0;
      acc_reg <= {ACC_W{1'b0}};
      drk_reg <= {ACC_W{1'b0}};
      ADC_CONVERT_OUT <= 1'b0;
      DEC_VALID_OUT <= 1'b0;
      DEC_SLOT_OUT <= 1'b0;
      DEC_DATA_OUT <= {ACC_W{1'b0}};
      DEC_DARK_OUT <= {ACC_W{1'b0}};
      FIFO_WR_OUT <= 1'b0;
      FIFO_FMT_OUT <= 3'h0;
      res_a_reg <= {ACC_W{1'b0}};
      drk_a_reg <= {ACC_W{1'b0}};
      res_b_reg <= {ACC_W{1'b0}};
      drk_b_reg <= {ACC_W{1'b0}};
    end else begin
      ADC_CONVERT_OUT <= 1'b0;
      DEC_VALID_OUT <= 1'b0;
      FIFO_WR_OUT <= 1'b0;
      tick_reg <= tick ? 6'h00 : tick_reg + 6'h01;
      // Result of the pending conversion
      if (ADC_VALID_IN & pend_reg) begin
        pend_reg <= 1'b0;
        if (pend_neg_reg) begin
          acc_reg <= acc_reg - samp_x;
          drk_reg <= drk_reg + samp_x;
        end else begin
          acc_reg <= acc_reg + samp_x;
        end
      end
      case (state_reg)
        S_IDLE: begin
          // Restarts while busy are ignored: one result per window
          if (go) begin
            state_reg <= S_WAIT;
            slot_reg <= go_b;
            tick_reg <= 6'h00;
            cnt_reg <= {1'b0, st8} + BIAS;
            acc_reg <= {ACC_W{1'b0}};
            drk_reg <= {ACC_W{1'b0}};
            pend_reg <= 1'b0;
          end
        end
        S_WAIT: begin
          if (tick) begin
            if (cnt_reg <= TWO9) begin
              state_reg <= S_NEG1;
              cnt_reg <= w9;
            end else begin
              cnt_reg <= cnt_reg - ONE9;
            end
          end
        end
        S_NEG1: begin
          if (tick) begin
            if (cnt_reg == ONE9) begin
              if (gapped & (gap8 != 8'h00)) begin
                state_reg <= S_GAP;
                cnt_reg <= {1'b0, gap8};
              end else begin
                state_reg <= S_POS;
                cnt_reg <= pos_len;
              end
            end else begin
              cnt_reg <= cnt_reg - ONE9;
            end
          end
        end
        S_GAP: begin
          if (tick) begin
            if (cnt_reg == ONE9) begin
              state_reg <= S_POS;
              cnt_reg <= pos_len;
            end else begin
              cnt_reg <= cnt_reg - ONE9;
            end
          end
        end
        S_POS: begin
          if (tick) begin
            if (cnt_reg == ONE9) begin
              state_reg <= pair1 ? S_FIN : S_NEG2;
              cnt_reg <= w9;
            end else begin
              cnt_reg <= cnt_reg - ONE9;
            end
          end
        end
        S_NEG2: begin
          if (tick) begin
            if (cnt_reg == ONE9) begin
              state_reg <= S_FIN;
            end else begin
              cnt_reg <= cnt_reg - ONE9;
            end
          end
        end
        S_FIN: begin
          // Wait for the last conversion before handing on
          if (~pend_reg | ADC_VALID_IN) begin
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
      // One conversion per microsecond in each region
      if (tick & in_region) begin
        ADC_CONVERT_OUT <= 1'b1;
        pend_reg <= 1'b1;
        pend_neg_reg <= (state_reg != S_POS);
      end
      // Hand the window sum on
      if ((state_reg == S_FIN) & (~pend_reg | ADC_VALID_IN)) begin
        DEC_VALID_OUT <= 1'b1;
        DEC_SLOT_OUT <= slot_reg;
        DEC_DATA_OUT <= final_sum;
        DEC_DARK_OUT <= final_drk;
        FIFO_WR_OUT <= (fmt != 3'h0);
        FIFO_FMT_OUT <= fmt;
        if (slot_reg) begin
          res_b_reg <= final_sum;
          drk_b_reg <= final_drk;
        end else begin
          res_a_reg <= final_sum;
          drk_a_reg <= final_drk;
        end
      end
    end
  end

  always @* begin
    final_sum = acc_reg;
    final_drk = drk_reg;
    if (ADC_VALID_IN & pend_reg) begin
      if (pend_neg_reg) begin
        final_sum = acc_reg - samp_x;
        final_drk = drk_reg + samp_x;
      end else begin
        final_sum = acc_reg + samp_x;
      end
    end
  end

  // ----------------------------------------
  // Analog control outputs
  // ----------------------------------------
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      BPF_BYPASS_OUT <= 1'b0;
      INTEG_BUFFER_OUT <= 1'b0;
      SINGLE_CHANNEL_OUT <= 1'b0;
      CH_POWER_DOWN_OUT <= 3'h0;
      PD_SELECT_OUT <= 4'h0;
      PD_CONNECT_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
    end else begin
      BPF_BYPASS_OUT <= (state_reg != S_IDLE) | go;
      INTEG_BUFFER_OUT <= (state_reg != S_IDLE) | go;
      SINGLE_CHANNEL_OUT <= single;
      CH_POWER_DOWN_OUT <= pwr_reg[`ODI_F_PWR_HI:`ODI_F_PWR_LO];
      PD_SELECT_OUT <= pd8;
      PD_CONNECT_OUT <= (pd8 != 4'h0);
      BUSY_OUT <= (state_reg != S_IDLE);
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Third location gives a clipped 16-bit view
  function [15:0] clip16;
    input [ACC_W-1:0] v;
    begin
      if (v[ACC_W-1]) begin
        clip16 = 16'h0000;
      end else if (v[ACC_W-2:16] != {(ACC_W-17){1'b0}}) begin
        clip16 = 16'hffff;
      end else begin
        clip16 = v[15:0];
      end
    end
  endfunction

  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      fifo_cfg_reg <= `ODI_RST_16;
      pd_sel_reg <= `ODI_RST_16;
      chan_reg <= `ODI_RST_16;
      pwr_reg <= `ODI_RST_16;
      mode_reg <= `ODI_RST_16;
      di_cfg_reg <= `ODI_RST_16;
      start_a_reg <= 8'h00;
      width_a_reg <= 8'h01;
      gap_a_reg <= 8'h00;
      start_b_reg <= 8'h00;
      width_b_reg <= 8'h01;
      gap_b_reg <= 8'h00;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == `ODI_A_FIFO_CFG) begin
        fifo_cfg_reg <= REG_WDATA_IN;
      end else if (REG_ADDR_IN == `ODI_A_PD_SEL) begin
        pd_sel_reg <= REG_WDATA_IN;
      end else if (REG_ADDR_IN == `ODI_A_CHAN) begin
        chan_reg <= REG_WDATA_IN;
      end else if (REG_ADDR_IN == `ODI_A_PWR) begin
        pwr_reg <= REG_WDATA_IN;
      end else if (REG_ADDR_IN == `ODI_A_MODE) begin
        mode_reg <= REG_WDATA_IN;
      end else if (REG_ADDR_IN == `ODI_A_DI_CFG) begin
        di_cfg_reg <= REG_WDATA_IN;
      end else if (REG_ADDR_IN == `ODI_A_START_A) begin
        start_a_reg <= REG_WDATA_IN[7:0];
      end else if (REG_ADDR_IN == `ODI_A_WIDTH_A) begin
        width_a_reg <= REG_WDATA_IN[7:0];
      end else if (REG_ADDR_IN == `ODI_A_GAP_A) begin
        gap_a_reg <= REG_WDATA_IN[7:0];
      end else if (REG_ADDR_IN == `ODI_A_START_B) begin
        start_b_reg <= REG_WDATA_IN[7:0];
      end else if (REG_ADDR_IN == `ODI_A_WIDTH_B) begin
        width_b_reg <= REG_WDATA_IN[7:0];
      end else if (REG_ADDR_IN == `ODI_A_GAP_B) begin
        gap_b_reg <= REG_WDATA_IN[7:0];
      end
    end
  end

  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= 16'h0000;
    end else if (REG_RD_IN) begin
      if (REG_ADDR_IN == `ODI_A_FIFO_CFG) begin
        REG_RDATA_OUT <= fifo_cfg_reg;
      end else if (REG_ADDR_IN == `ODI_A_PD_SEL) begin
        REG_RDATA_OUT <= pd_sel_reg;
      end else if (REG_ADDR_IN == `ODI_A_CHAN) begin
        REG_RDATA_OUT <= chan_reg;
      end else if (REG_ADDR_IN == `ODI_A_PWR) begin
        REG_RDATA_OUT <= pwr_reg;
      end else if (REG_ADDR_IN == `ODI_A_MODE) begin
        REG_RDATA_OUT <= mode_reg;
      end else if (REG_ADDR_IN == `ODI_A_DI_CFG) begin
        REG_RDATA_OUT <= di_cfg_reg;
      end else if (REG_ADDR_IN == `ODI_A_START_A) begin
        REG_RDATA_OUT <= {8'h00, start_a_reg};
      end else if (REG_ADDR_IN == `ODI_A_WIDTH_A) begin
        REG_RDATA_OUT <= {8'h00, width_a_reg};
      end else if (REG_ADDR_IN == `ODI_A_GAP_A) begin
        REG_RDATA_OUT <= {8'h00, gap_a_reg};
      end else if (REG_ADDR_IN == `ODI_A_START_B) begin
        REG_RDATA_OUT <= {8'h00, start_b_reg};
      end else if (REG_ADDR_IN == `ODI_A_WIDTH_B) begin
        REG_RDATA_OUT <= {8'h00, width_b_reg};
      end else if (REG_ADDR_IN == `ODI_A_GAP_B) begin
        REG_RDATA_OUT <= {8'h00, gap_b_reg};
      end else if (REG_ADDR_IN == `ODI_A_RES_A0) begin
        REG_RDATA_OUT <= res_a_reg[15:0];
      end else if (REG_ADDR_IN == `ODI_A_RES_A1) begin
        REG_RDATA_OUT <= res_a_reg[31:16];
      end else if (REG_ADDR_IN == `ODI_A_RES_A2) begin
        REG_RDATA_OUT <= clip16(res_a_reg);
      end else if (REG_ADDR_IN == `ODI_A_RES_B0) begin
        REG_RDATA_OUT <= res_b_reg[15:0];
      end else if (REG_ADDR_IN == `ODI_A_RES_B1) begin
        REG_RDATA_OUT <= res_b_reg[31:16];
      end else if (REG_ADDR_IN == `ODI_A_RES_B2) begin
        REG_RDATA_OUT <= clip16(res_b_reg);
      end else if (REG_ADDR_IN == `ODI_A_DRK_A0) begin
        REG_RDATA_OUT <= drk_a_reg[15:0];
      end else if (REG_ADDR_IN == `ODI_A_DRK_A1) begin
        REG_RDATA_OUT <= drk_a_reg[31:16];
      end else if (REG_ADDR_IN == `ODI_A_DRK_B0) begin
        REG_RDATA_OUT <= drk_b_reg[15:0];
      end else if (REG_ADDR_IN == `ODI_A_DRK_B1) begin
        REG_RDATA_OUT <= drk_b_reg[31:16];
      end else begin
        REG_RDATA_OUT <= 16'h0000;
      end
    end
  end

endmodule
`default_nettype wire

/* File: src/odi_regs.vh */
`ifndef ODI_REGS_VH
`define ODI_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ODI_A_FIFO_CFG 8'h11
`define ODI_A_PD_SEL 8'h14
`define ODI_A_CHAN 8'h54
`define ODI_A_PWR 8'h55
`define ODI_A_MODE 8'h58
`define ODI_A_DI_CFG 8'h5a
`define ODI_A_RES_A0 8'h64
`define ODI_A_RES_A1 8'h70
`define ODI_A_RES_A2 8'h74
`define ODI_A_RES_B0 8'h68
`define ODI_A_RES_B1 8'h78
`define ODI_A_RES_B2 8'h7c
`define ODI_A_DRK_A0 8'h65
`define ODI_A_DRK_A1 8'h71
`define ODI_A_DRK_B0 8'h69
`define ODI_A_DRK_B1 8'h79
`define ODI_A_START_A 8'h80
`define ODI_A_WIDTH_A 8'h81
`define ODI_A_GAP_A 8'h82
`define ODI_A_START_B 8'h83
`define ODI_A_WIDTH_B 8'h84
`define ODI_A_GAP_B 8'h85
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ODI_B_DI_EN_A 12
`define ODI_B_DI_EN_B 13
`define ODI_B_SINGLE_A 14
`define ODI_B_SINGLE_B 15
`define ODI_F_PWR_HI 15
`define ODI_F_PWR_LO 13
`define ODI_B_PAIR1_A 5
`define ODI_B_PAIR1_B 6
`define ODI_B_GAPPED 7
`define ODI_F_FIFO_A_HI 4
`define ODI_F_FIFO_A_LO 2
`define ODI_F_FIFO_B_HI 8
`define ODI_F_FIFO_B_LO 6
`define ODI_F_PD_A_HI 7
`define ODI_F_PD_A_LO 4
`define ODI_F_PD_B_HI 11
`define ODI_F_PD_B_LO 8
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ODI_RST_16 16'h0000
`define ODI_RST_W 16'h0001
`define ODI_START_BIAS 9
`define ODI_CONV_PERIOD_NS 1000
`define ODI_CLK_PERIOD_NS 20
`endif

/* File: sim/odi_integrator_chk.sv */
`default_nettype none
module odi_integrator_chk #(
  parameter ADC_W = 14,
  parameter ACC_W = 32
) (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // Watched ports
  input wire logic SLOT_A_START_IN,
  input wire logic SLOT_B_START_IN,
  input wire logic ADC_CONVERT_OUT,
  input wire logic BPF_BYPASS_OUT,
  input wire logic INTEG_BUFFER_OUT,
  input wire logic [3:0] PD_SELECT_OUT,
  input wire logic PD_CONNECT_OUT,
  input wire logic DEC_VALID_OUT,
  input wire logic [ACC_W-1:0] DEC_DATA_OUT,
  input wire logic [ACC_W-1:0] DEC_DARK_OUT,
  input wire logic FIFO_WR_OUT,
  input wire logic [2:0] FIFO_FMT_OUT,
  input wire logic BUSY_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  // Cycles since a start seen while BUSY_OUT is low, accepted or not; a start while BUSY_OUT is high must not move it
  logic [15:0] tick_reg;
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN || ((SLOT_A_START_IN || SLOT_B_START_IN) && !BUSY_OUT))
      tick_reg <= 16'h0;
    else
      tick_reg <= tick_reg + 16'h1;
  end
  conv_tick_a: assert property (ADC_CONVERT_OUT |-> tick_reg % 50 == 0)
    else $error("conversion off the microsecond grid");
  conv_gap_a: assert property (ADC_CONVERT_OUT |=> !ADC_CONVERT_OUT [*8])
    else $error("conversions too close");
  conv_mode_a: assert property (ADC_CONVERT_OUT |-> BUSY_OUT && BPF_BYPASS_OUT && INTEG_BUFFER_OUT)
    else $error("conversion outside a bypassed window");
  busy_start_a: assert property ($rose(BUSY_OUT) |-> $past(SLOT_A_START_IN || SLOT_B_START_IN, 2))
    else $error("window began without a start");
  dec_pulse_a: assert property (DEC_VALID_OUT |=> !DEC_VALID_OUT)
    else $error("result strobe longer than one cycle");
  dec_end_a: assert property (DEC_VALID_OUT |-> ##[1:2] !BUSY_OUT)
    else $error("engine still busy after result");
  dec_hold_a: assert property (
    !$past(RST_IN) && ($changed(DEC_DATA_OUT) || $changed(DEC_DARK_OUT)) |-> DEC_VALID_OUT)
    else $error("result changed without strobe");
  fifo_fmt_a: assert property (DEC_VALID_OUT |-> FIFO_WR_OUT == (FIFO_FMT_OUT != 3'h0))
    else $error("fifo write disagrees with format");
  fifo_only_a: assert property (FIFO_WR_OUT |-> DEC_VALID_OUT)
    else $error("fifo write without result");
  pd_link_a: assert property (PD_CONNECT_OUT == (PD_SELECT_OUT != 4'h0))
    else $error("photodiode connect disagrees with select");
endmodule
bind odi_integrator odi_integrator_chk #(.ADC_W(ADC_W), .ACC_W(ACC_W)) odi_integrator_chk_inst (.*);
`default_nettype wire

/* File: sim/odi_adc_model.sv */
`default_nettype none
module odi_adc_model (
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic win_start_in,
  input wire logic [5:0] lag_in,
  input wire logic [13:0] base_in,
  // Converter handshake
  input wire logic convert_in,
  output var logic valid_out,
  output var logic [55:0] ch_out
);
  logic pend_reg;
  logic [5:0] wait_reg;
  logic [13:0] num_reg;
  initial {valid_out, ch_out} = 57'h0;
  always @(posedge clk_in) begin
    valid_out <= 1'b0;
    // Idle lines toggle so a stale value never looks like a sample
    ch_out <= ~ch_out;
    if (rst_in) begin
      pend_reg <= 1'b0;
      num_reg <= 14'h0;
    end else if (win_start_in) begin
      num_reg <= 14'h0;
    end else if (convert_in) begin
      pend_reg <= 1'b1;
      wait_reg <= lag_in;
    end else if (pend_reg && wait_reg != 6'h0) begin
      wait_reg <= wait_reg - 6'h1;
    end else if (pend_reg) begin
      pend_reg <= 1'b0;
      valid_out <= 1'b1;
      num_reg <= num_reg + 14'h1;
      // Light ramps up through the window, so early regions are the darkest
      for (int k = 0; k < 4; k++)
        ch_out[14*k +: 14] <= base_in + 14'(4 * num_reg) + 14'(k);
    end
  end
endmodule
`default_nettype wire

/* File: sim/odi_integrator_bench.sv */
`include "odi_regs.vh"
`default_nettype none
module odi_integrator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // -----
  // Signals
  // -----
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sa = 1'b0, sb = 1'b0, rd_d = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, tcnt = 16'h0000, rdata;
  logic [5:0] lag = 6'h00;
  logic [13:0] base = 14'h0000;
  logic [55:0] ch;
  logic [31:0] ddat, ddrk;
  logic [3:0] pds;
  logic [2:0] pwr, fmto;
  logic vld, conv, bpf, intg, sgl, pdc, dv, dslot, fwr, busy;
  logic [31:0] exp_q[$];
  logic [7:0] ra [2][5] = '{'{`ODI_A_RES_A0, `ODI_A_RES_A1, `ODI_A_RES_A2, `ODI_A_DRK_A0, `ODI_A_DRK_A1},
    '{`ODI_A_RES_B0, `ODI_A_RES_B1, `ODI_A_RES_B2, `ODI_A_DRK_B0, `ODI_A_DRK_B1}};
  integer seed = 32'h5d1f;
  int cv = 0, w = 1, bad_count = 0, cmp_count = 0;
  odi_integrator odi_integrator_inst (.CLK_SYS_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .SLOT_A_START_IN(sa), .SLOT_B_START_IN(sb), .ADC_CH1_IN(ch[13:0]), .ADC_CH2_IN(ch[27:14]),
    .ADC_CH3_IN(ch[41:28]), .ADC_CH4_IN(ch[55:42]), .ADC_VALID_IN(vld), .ADC_CONVERT_OUT(conv),
    .BPF_BYPASS_OUT(bpf), .INTEG_BUFFER_OUT(intg), .SINGLE_CHANNEL_OUT(sgl), .CH_POWER_DOWN_OUT(pwr),
    .PD_SELECT_OUT(pds), .PD_CONNECT_OUT(pdc), .DEC_VALID_OUT(dv), .DEC_SLOT_OUT(dslot),
    .DEC_DATA_OUT(ddat), .DEC_DARK_OUT(ddrk), .FIFO_WR_OUT(fwr), .FIFO_FMT_OUT(fmto), .BUSY_OUT(busy));
  odi_adc_model odi_adc_model_inst (.clk_in(clk), .rst_in(rst), .win_start_in(sa | sb), .lag_in(lag),
    .base_in(base), .convert_in(conv), .valid_out(vld), .ch_out(ch));
  initial forever #10 clk = ~clk;
  // -----
  // Checks
  // -----
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pop(input logic [31:0] got);
    cmp(got, exp_q.size() ? exp_q.pop_front() : 32'hz);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    tcnt <= tcnt + 16'h1;
    if (rd_d)
      pop({16'h0, rdata});
    if (conv) begin
      cv <= cv + 1;
      if (cv == 0 || cv == w)
        pop({pdc, pds, sgl, bpf, intg, 8'h00, tcnt});
    end
    if (dv) begin
      pop(ddat);
      pop(ddrk);
      pop({27'h0, fwr, fmto, dslot});
    end
    if (sa | sb) begin
      cv <= 0;
      tcnt <= 16'h0;
    end
  end
  // -----
  // Stimulus
  // -----
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic go(input logic sl);
    int k;
    @(posedge clk);
    sa <= !sl;
    sb <= sl;
    @(posedge clk);
    sa <= 1'b0;
    sb <= 1'b0;
    // Busy only shows one edge after the start is taken
    repeat (2) @(posedge clk);
    for (k = 0; k < 3000; k++) begin
      @(posedge clk);
      if (busy === 1'b0)
        break;
    end
    if (k == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  initial begin
    int st, g, tot, dat, drk, v;
    int cf[3];
    logic sl, p, gp, sc;
    logic [2:0] fmt;
    logic [3:0] pa, pb, pe;
    logic [15:0] hd;
    logic [31:0] last_a;
    logic [31:0] ev[5];
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wreg(`ODI_A_PWR, 16'he000);
    repeat (2) @(posedge clk);
    cmp({29'h0, pwr}, 32'h7);
    wreg(`ODI_A_PWR, 16'h0000);
    repeat (2) @(posedge clk);
    cmp({29'h0, pwr}, 32'h0);
    // Every slot, pairing and gap combination; quick converter without the gap, slow converter with it
    for (int i = 0; i < 8; i++) begin
      {gp, p, sl} = 3'(i);
      w = 1 + $unsigned($random(seed)) % 3;
      st = $unsigned($random(seed)) % 3;
      g = 1 + $unsigned($random(seed)) % 3;
      {sc, fmt, pa, pb} = 12'($random(seed));
      if (i == 2)
        pa = 4'h0;
      base = 14'($unsigned($random(seed)) % 4096);
      lag = (i < 4) ? 6'd0 : 6'd40;
      wreg(`ODI_A_MODE, 16'h1000 << sl);
      wreg(`ODI_A_DI_CFG, {8'h00, gp, p & sl, p & !sl, 5'h00});
      wreg(`ODI_A_CHAN, {sc & sl, sc & !sl, 14'h0});
      wreg(`ODI_A_FIFO_CFG, sl ? {7'h0, fmt, 6'h0} : {11'h0, fmt, 2'h0});
      wreg(`ODI_A_PD_SEL, {4'h0, pb, pa, 4'h0});
      cf = '{st, w, g};
      for (int j = 0; j < 3; j++)
        wreg(8'(`ODI_A_START_A + 3 * sl + j), 16'(cf[j]));
      rreg(`ODI_A_MODE, 32'h1000 << sl);
      tot = p ? 2 * w : 4 * w;
      dat = 0;
      drk = 0;
      for (int n = 0; n < tot; n++) begin
        v = sc ? base + 4 * n : 4 * base + 16 * n + 6;
        if (n < w || n >= 3 * w) begin
          dat -= v;
          drk += v;
        end else begin
          dat += v;
        end
      end
      pe = sl ? pb : pa;
      hd = {pe != 4'h0, pe, sc, 2'b11, 8'h00};
      exp_q.push_back({hd, 16'(50 * (st + 9))});
      exp_q.push_back({hd, 16'(50 * (st + 9 + w + (gp ? g : 0)))});
      exp_q.push_back(dat);
      exp_q.push_back(drk);
      exp_q.push_back({27'h0, fmt != 3'h0, fmt, sl});
      go(sl);
      ev = '{dat[15:0], dat[31:16], dat < 0 ? 0 : dat > 65535 ? 65535 : dat, drk[15:0], drk[31:16]};
      for (int j = 0; j < 5; j++)
        rreg(ra[sl][j], ev[j]);
      if (!sl)
        last_a = ev[0];
    end
    wreg(`ODI_A_RES_A0, 16'hffff);
    rreg(`ODI_A_RES_A0, last_a);
    rreg(8'h3f, 32'h0);
    wreg(`ODI_A_MODE, 16'h1000);
    go(1'b1);
    wreg(`ODI_A_MODE, 16'h0000);
    go(1'b0);
    cmp(exp_q.size(), 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
